// ### design/analog_input_calibration_ctrl.sv
// Calibration control for four analog input channels.
// Assumes one-cycle register write/read strobes from a protocol engine and
// raw converter samples that are already synchronous to sys_clk.
`include "cal_params.svh"
`default_nettype none

module analog_input_calibration_ctrl
    import cal_pkg::*;
(
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire logic                     reg_wr_en,
    input  wire logic                     reg_rd_en,
    input  wire logic [15:0]              reg_addr,
    input  wire logic [15:0]              reg_wr_data,
    input  wire logic [NUM_CH-1:0][15:0]  analog_input_channel,
    output logic      [15:0]              reg_rd_data,
    output logic                          reg_rd_valid,
    output logic                          cal_unlocked,
    output logic      [NUM_CH-1:0][15:0]  zero_endpoint,
    output logic      [NUM_CH-1:0][15:0]  full_scale_endpoint,
    output logic      [NUM_CH-1:0][15:0]  ref_zero,
    output logic      [NUM_CH-1:0][15:0]  ref_full_scale,
    output logic      [NUM_CH-1:0]        range_valid
);

    // ============================================================
    // Address decode
    logic wr_key;
    logic wr_zero;
    logic wr_span;
    logic unlocked;
    logic [NUM_CH-1:0] wr_range;

    assign wr_key  = reg_wr_en && (reg_addr == `CAL_ADDR_KEY);
    assign wr_zero = reg_wr_en && (reg_addr == `CAL_ADDR_ZERO_TRIG);
    assign wr_span = reg_wr_en && (reg_addr == `CAL_ADDR_SPAN_TRIG);

    // ============================================================
    // Key register
    logic [15:0] key_q;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            key_q <= `CAL_KEY_RESET;
        end
        else if (wr_key)
        begin
            // Any value but the key, zero included, locks the triggers again
            key_q <= reg_wr_data;
        end
    end

    assign unlocked = (key_q == `CAL_UNLOCK_KEY);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cal_unlocked <= 1'b0;
        end
        else
        begin
            cal_unlocked <= wr_key ? (reg_wr_data == `CAL_UNLOCK_KEY) : unlocked;
        end
    end

    // ============================================================
    // Trigger masks, gated by the lock; upper mask bits fall away
    logic [NUM_CH-1:0] zero_hit;
    logic [NUM_CH-1:0] span_hit;

    assign zero_hit = (wr_zero && unlocked) ? reg_wr_data[NUM_CH-1:0] : '0;
    assign span_hit = (wr_span && unlocked) ? reg_wr_data[NUM_CH-1:0] : '0;

    // ============================================================
    // Capture flags since the last key write, for software to confirm progress
    logic [NUM_CH-1:0] zero_done_q;
    logic [NUM_CH-1:0] span_done_q;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            zero_done_q <= '0;
            span_done_q <= '0;
        end
        else if (wr_key)
        begin
            zero_done_q <= '0;
            span_done_q <= '0;
        end
        else
        begin
            zero_done_q <= zero_done_q | zero_hit;
            span_done_q <= span_done_q | span_hit;
        end
    end

    // ============================================================
    // Per-channel range select, coefficient storage and outputs
    range_t [NUM_CH-1:0] range_q;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++)
        begin : g_chan
            logic [15:0] zero_store_q [NUM_SLOTS];
            logic [15:0] span_store_q [NUM_SLOTS];
            slot_t       slot;
            logic        slot_ok;
            logic [15:0] rz;
            logic [15:0] rf;

            assign wr_range[ch] = reg_wr_en &&
                (reg_addr == (`CAL_ADDR_RANGE_BASE + 16'(ch)));

            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    range_q[ch] <= range_t'(`CAL_RANGE_RESET);
                end
                else if (wr_range[ch])
                begin
                    range_q[ch] <= range_t'(reg_wr_data[2:0]);
                end
            end

            // Map range to coefficient set and fixed endpoint references
            always_comb
            begin
                slot    = 3'h0;
                slot_ok = 1'b1;
                rz      = 16'h0000;
                rf      = 16'h0000;
                case (range_q[ch])
                    RANGE_0_20MA, RANGE_4_20MA:
                    begin
                        slot = 3'h0;
                        rz   = `CAL_REF_Z_0_20MA;
                        rf   = `CAL_REF_F_0_20MA;
                    end
                    RANGE_0_11MA:
                    begin
                        slot = 3'h1;
                        rz   = `CAL_REF_Z_0_11MA;
                        rf   = `CAL_REF_F_0_11MA;
                    end
                    RANGE_0_1MA:
                    begin
                        slot = 3'h2;
                        rz   = `CAL_REF_Z_0_1MA;
                        rf   = `CAL_REF_F_0_1MA;
                    end
                    RANGE_BIP_10V:
                    begin
                        slot = 3'h3;
                        rz   = `CAL_REF_Z_10V;
                        rf   = `CAL_REF_F_10V;
                    end
                    RANGE_BIP_5V:
                    begin
                        slot = 3'h4;
                        rz   = `CAL_REF_Z_5V;
                        rf   = `CAL_REF_F_5V;
                    end
                    RANGE_BIP_1V:
                    begin
                        slot = 3'h5;
                        rz   = `CAL_REF_Z_1V;
                        rf   = `CAL_REF_F_1V;
                    end
                    default:
                    begin
                        // Unassigned code: nothing is captured into any set
                        slot_ok = 1'b0;
                    end
                endcase
            end

            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    for (int s = 0; s < NUM_SLOTS; s++)
                    begin
                        zero_store_q[s] <= `CAL_ZERO_RESET;
                        span_store_q[s] <= `CAL_SPAN_RESET;
                    end
                end
                else if (slot_ok)
                begin
                    if (zero_hit[ch])
                    begin
                        zero_store_q[slot] <= analog_input_channel[ch];
                    end
                    if (span_hit[ch])
                    begin
                        span_store_q[slot] <= analog_input_channel[ch];
                    end
                end
            end

            // Fresh sample is forwarded so the new value shows the next cycle
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    zero_endpoint[ch]       <= `CAL_ZERO_RESET;
                    full_scale_endpoint[ch] <= `CAL_SPAN_RESET;
                    ref_zero[ch]            <= 16'h0000;
                    ref_full_scale[ch]      <= 16'h0000;
                    range_valid[ch]         <= 1'b0;
                end
                else
                begin
                    zero_endpoint[ch]       <= !slot_ok ? 16'h0000 :
                        zero_hit[ch] ? analog_input_channel[ch] : zero_store_q[slot];
                    full_scale_endpoint[ch] <= !slot_ok ? 16'h0000 :
                        span_hit[ch] ? analog_input_channel[ch] : span_store_q[slot];
                    ref_zero[ch]            <= rz;
                    ref_full_scale[ch]      <= rf;
                    range_valid[ch]         <= slot_ok;
                end
            end
        end
    endgenerate

    // ============================================================
    // Register read-back; trigger registers and unmapped addresses read zero
    logic [15:0] rd_mux;

    always_comb
    begin
        rd_mux = 16'h0000;
        if (reg_addr == `CAL_ADDR_KEY)
        begin
            rd_mux = key_q;
        end
        else if (reg_addr == `CAL_ADDR_STATUS)
        begin
            rd_mux[`CAL_STAT_ZERO_LSB +: NUM_CH] = zero_done_q;
            rd_mux[`CAL_STAT_SPAN_LSB +: NUM_CH] = span_done_q;
            rd_mux[`CAL_STAT_UNLOCK_BIT]         = unlocked;
        end
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (reg_addr == (`CAL_ADDR_RANGE_BASE + 16'(i)))
                begin
                    rd_mux = {13'h0, range_q[i]};
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rd_data  <= 16'h0000;
            reg_rd_valid <= 1'b0;
        end
        else
        begin
            reg_rd_valid <= reg_rd_en;
            reg_rd_data  <= reg_rd_en ? rd_mux : 16'h0000;
        end
    end

endmodule

`default_nettype wire

// ### design/cal_params.svh
// Constants for the analog input calibration control block.
// Assumes a 16-bit holding-register write/read port driven by the protocol engine.
//
// Behaviour
// - Trigger registers stay write-protected until the unlock key is written to the key register.
// - Writing zero to the key register restores write protection on the trigger registers.
// - A zero-trigger write with bit n set captures the zero endpoint of input channel n.
// - A capture replaces the channel's coefficients at once, with no reset or restart.
// - A span-trigger write with bit n set captures the full-scale endpoint of channel n.
// - A capture lands in the coefficient set of the range selected for that channel.
// - The 4-20mA range shares the 0-20mA coefficient set and needs no capture of its own.
// - The 0-1mA and 0-11.17mA ranges each keep their own independent coefficient set.
// - Each range has fixed endpoint references: 1.0/20.0mA, 1.0/11.17mA, 0.25/1.0mA, +-V.
`ifndef CAL_PARAMS_SVH
`define CAL_PARAMS_SVH

// ============================================================
// Register addresses
`define CAL_ADDR_KEY        16'h0000
`define CAL_ADDR_ZERO_TRIG  16'h0001
`define CAL_ADDR_SPAN_TRIG  16'h0002
`define CAL_ADDR_STATUS     16'h0003
`define CAL_ADDR_RANGE_BASE 16'h0010

// ============================================================
// Key and reset values
`define CAL_UNLOCK_KEY      16'h5E2A
`define CAL_KEY_RESET       16'h0000
`define CAL_RANGE_RESET     3'h0
`define CAL_ZERO_RESET      16'h0000
`define CAL_SPAN_RESET      16'h7FFF

// ============================================================
// Status fields
`define CAL_STAT_ZERO_LSB   0
`define CAL_STAT_SPAN_LSB   4
`define CAL_STAT_UNLOCK_BIT 8

// ============================================================
// Endpoint references, microamps for current ranges, millivolts for voltage
`define CAL_REF_Z_0_20MA    16'h03E8
`define CAL_REF_F_0_20MA    16'h4E20
`define CAL_REF_Z_0_11MA    16'h03E8
`define CAL_REF_F_0_11MA    16'h2BA2
`define CAL_REF_Z_0_1MA     16'h00FA
`define CAL_REF_F_0_1MA     16'h03E8
`define CAL_REF_Z_10V       16'hD8F0
`define CAL_REF_F_10V       16'h2710
`define CAL_REF_Z_5V        16'hEC78
`define CAL_REF_F_5V        16'h1388
`define CAL_REF_Z_1V        16'hFC18
`define CAL_REF_F_1V        16'h03E8

`endif

// ### design/cal_pkg.sv
// Types shared by the analog input calibration control block.
// Assumes nothing beyond the constants header.
`default_nettype none

package cal_pkg;

    localparam int NUM_CH    = 4;
    localparam int NUM_SLOTS = 6;

    // ============================================================
    // Input range codes as written to a channel range register
    typedef enum logic [2:0] {
        RANGE_0_20MA  = 3'h0,
        RANGE_4_20MA  = 3'h1,
        RANGE_0_11MA  = 3'h2,
        RANGE_0_1MA   = 3'h3,
        RANGE_BIP_10V = 3'h4,
        RANGE_BIP_5V  = 3'h5,
        RANGE_BIP_1V  = 3'h6,
        RANGE_NONE    = 3'h7
    } range_t;

    typedef logic [2:0] slot_t;

endpackage

`default_nettype wire

// ### testbench/aicc_properties.sv
// Checker for the analog input calibration control block, bound to its ports.
// Assumes one sys_clk domain with an active-low asynchronous reset.
`include "cal_params.svh"
`default_nettype none

module aicc_properties
    import cal_pkg::*;
(
    input wire logic                    sys_clk,
    input wire logic                    rst_n,
    input wire logic                    reg_wr_en,
    input wire logic                    reg_rd_en,
    input wire logic [15:0]             reg_addr,
    input wire logic [15:0]             reg_wr_data,
    input wire logic [NUM_CH-1:0][15:0] analog_input_channel,
    input wire logic [15:0]             reg_rd_data,
    input wire logic                    reg_rd_valid,
    input wire logic                    cal_unlocked,
    input wire logic [NUM_CH-1:0][15:0] zero_endpoint,
    input wire logic [NUM_CH-1:0][15:0] full_scale_endpoint,
    input wire logic [NUM_CH-1:0][15:0] ref_zero,
    input wire logic [NUM_CH-1:0][15:0] ref_full_scale,
    input wire logic [NUM_CH-1:0]       range_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ============================================================
    // Trigger writes
    // A range write just before still moves the outputs one cycle later
    sequence s_zero_wr;
        !$past(reg_wr_en) && reg_wr_en && reg_addr == `CAL_ADDR_ZERO_TRIG;
    endsequence
    sequence s_span_wr;
        !$past(reg_wr_en) && reg_wr_en && reg_addr == `CAL_ADDR_SPAN_TRIG;
    endsequence

    a_locked_zero_held: assert property (s_zero_wr ##0 !cal_unlocked |=> $stable(zero_endpoint))
        else $error("zero trigger acted while locked");
    a_locked_span_held: assert property (s_span_wr ##0 !cal_unlocked |=>
        $stable(full_scale_endpoint))
        else $error("span trigger acted while locked");
    a_key_sets_lock: assert property (reg_wr_en && reg_addr == `CAL_ADDR_KEY |=>
        cal_unlocked == ($past(reg_wr_data) == `CAL_UNLOCK_KEY))
        else $error("lock state does not follow key write");
    a_zero_capture: assert property (s_zero_wr ##0 (cal_unlocked && reg_wr_data[0] &&
        range_valid[0]) |=> zero_endpoint[0] == $past(analog_input_channel[0]))
        else $error("zero capture of channel 0 wrong");
    a_span_capture: assert property (s_span_wr ##0 (cal_unlocked && reg_wr_data[3] &&
        range_valid[3]) |=> full_scale_endpoint[3] == $past(analog_input_channel[3]))
        else $error("span capture of channel 3 wrong");
    a_high_mask_ignored: assert property (s_zero_wr ##0 reg_wr_data[3:0] == 4'h0 |=>
        $stable(zero_endpoint))
        else $error("mask bits above 3 acted");
    a_no_range_blank: assert property (!range_valid[0] |->
        zero_endpoint[0] == 16'h0000 && ref_zero[0] == 16'h0000)
        else $error("unselected range shows values");
    a_ref_pair_small: assert property (ref_zero[0] == `CAL_REF_Z_0_1MA |->
        ref_full_scale[0] == `CAL_REF_F_0_1MA)
        else $error("reference pair mismatch");
    a_read_pulse: assert property (reg_rd_en |=> reg_rd_valid ##1 !reg_rd_valid || $past(reg_rd_en))
        else $error("read valid not a one-cycle answer");
endmodule

bind analog_input_calibration_ctrl aicc_properties aicc_properties_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .analog_input_channel(analog_input_channel), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .cal_unlocked(cal_unlocked),
    .zero_endpoint(zero_endpoint), .full_scale_endpoint(full_scale_endpoint),
    .ref_zero(ref_zero), .ref_full_scale(ref_full_scale), .range_valid(range_valid)
);

`default_nettype wire

// ### testbench/analog_input_calibration_ctrl_tb_top.sv
// Self-checking bench for the analog input calibration control block.
// Assumes one-cycle register strobes taken on sys_clk rising edges.
`include "cal_params.svh"
`default_nettype none

module analog_input_calibration_ctrl_tb_top
    import cal_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                    sys_clk = 1'b0;
    logic                    rst_n = 1'b0;
    logic                    reg_wr_en = 1'b0;
    logic                    reg_rd_en = 1'b0;
    logic [15:0]             reg_addr = 16'h0000;
    logic [15:0]             reg_wr_data = 16'h0000;
    logic                    src_en = 1'b0;
    logic [1:0]              src_ch = 2'h0;
    logic [15:0]             src_lvl = 16'h0000;
    logic [NUM_CH-1:0][15:0] ain, zero_ep, full_ep, ref_z, ref_f;
    logic [15:0]             rd_data, rd_q;
    logic                    rd_valid, unlocked;
    logic [NUM_CH-1:0]       rng_ok;
    int                      n_fail = 0;
    int                      total_checks = 0;
    int                      cycles = 0;

    analog_input_calibration_ctrl analog_input_calibration_ctrl_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .analog_input_channel(ain),
        .reg_rd_data(rd_data), .reg_rd_valid(rd_valid), .cal_unlocked(unlocked),
        .zero_endpoint(zero_ep), .full_scale_endpoint(full_ep), .ref_zero(ref_z),
        .ref_full_scale(ref_f), .range_valid(rng_ok));
    cal_signal_source cal_signal_source_inst (.sys_clk(sys_clk), .set_en(src_en),
        .set_ch(src_ch), .set_level(src_lvl), .analog_input_channel(ain));

    // ============================================================
    // Tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wr_data = d;
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic rd(input logic [15:0] a);
        int i;
        @(negedge sys_clk);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd_en = 1'b0;
        for (i = 0; i < 4 && rd_valid !== 1'b1; i++)
            @(negedge sys_clk);
        rd_q = rd_data;
        check(rd_valid, 1'b1);
    endtask
    // Settling is shortened to ten cycles; the block does not time it
    task automatic src(input logic [1:0] ch, input logic [15:0] lvl);
        @(negedge sys_clk);
        src_en = 1'b1;
        src_ch = ch;
        src_lvl = lvl;
        @(negedge sys_clk);
        src_en = 1'b0;
        repeat (10) @(negedge sys_clk);
    endtask
    task automatic rng(input logic [2:0] c, input logic [15:0] z, f, ze);
        wr(`CAL_ADDR_RANGE_BASE, {13'h0, c});
        check(ref_z[0], z);
        check(ref_f[0], f);
        check(zero_ep[0], ze);
    endtask
    task automatic conclude();
        if (n_fail == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ============================================================
    // Clock, timeout and tests
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_fail++;
            conclude();
        end
    end
    initial
    begin
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        check(unlocked, 1'b0);
        check(full_ep[3], `CAL_SPAN_RESET);
        src(2'h0, 16'h0123);
        wr(`CAL_ADDR_ZERO_TRIG, 16'h0001);
        check(zero_ep[0], `CAL_ZERO_RESET);
        wr(`CAL_ADDR_KEY, `CAL_UNLOCK_KEY);
        check(unlocked, 1'b1);
        rd(`CAL_ADDR_KEY);
        check(rd_q, `CAL_UNLOCK_KEY);
        wr(`CAL_ADDR_ZERO_TRIG, 16'h0001);
        check(zero_ep[0], 16'h0123);
        check(zero_ep[1], `CAL_ZERO_RESET);
        src(2'h0, 16'h0456);
        wr(`CAL_ADDR_ZERO_TRIG, 16'hFFF0);
        check(zero_ep[0], 16'h0123);
        src(2'h3, 16'h7000);
        wr(`CAL_ADDR_SPAN_TRIG, 16'h0008);
        check(full_ep[3], 16'h7000);
        check(full_ep[0], `CAL_SPAN_RESET);
        rd(`CAL_ADDR_STATUS);
        check(rd_q, 16'h0181);
        rd(`CAL_ADDR_ZERO_TRIG);
        check(rd_q, 16'h0000);
        rd(16'h0100);
        check(rd_q, 16'h0000);
        rng(RANGE_0_1MA, `CAL_REF_Z_0_1MA, `CAL_REF_F_0_1MA, `CAL_ZERO_RESET);
        wr(`CAL_ADDR_ZERO_TRIG, 16'h0001);
        check(zero_ep[0], 16'h0456);
        rng(RANGE_0_11MA, `CAL_REF_Z_0_11MA, `CAL_REF_F_0_11MA, `CAL_ZERO_RESET);
        rng(RANGE_4_20MA, `CAL_REF_Z_0_20MA, `CAL_REF_F_0_20MA, 16'h0123);
        rng(RANGE_0_20MA, `CAL_REF_Z_0_20MA, `CAL_REF_F_0_20MA, 16'h0123);
        rng(RANGE_BIP_10V, `CAL_REF_Z_10V, `CAL_REF_F_10V, `CAL_ZERO_RESET);
        rng(RANGE_BIP_5V, `CAL_REF_Z_5V, `CAL_REF_F_5V, `CAL_ZERO_RESET);
        rng(RANGE_BIP_1V, `CAL_REF_Z_1V, `CAL_REF_F_1V, `CAL_ZERO_RESET);
        rng(RANGE_NONE, 16'h0000, 16'h0000, 16'h0000);
        check(rng_ok[0], 1'b0);
        rng(RANGE_0_1MA, `CAL_REF_Z_0_1MA, `CAL_REF_F_0_1MA, 16'h0456);
        wr(`CAL_ADDR_KEY, 16'h0000);
        check(unlocked, 1'b0);
        rd(`CAL_ADDR_STATUS);
        check(rd_q, 16'h0000);
        src(2'h3, 16'h1111);
        wr(`CAL_ADDR_SPAN_TRIG, 16'h0008);
        check(full_ep[3], 16'h7000);
        conclude();
    end
endmodule

`default_nettype wire

// ### testbench/cal_signal_source.sv
// Precision signal source feeding the four analog inputs.
// Assumes the bench sets one channel level at a time and waits for settling.
`default_nettype none

module cal_signal_source
    import cal_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    set_en,
    input  wire logic [1:0]              set_ch,
    input  wire logic [15:0]             set_level,
    output var  logic [NUM_CH-1:0][15:0] analog_input_channel
);
    timeunit 1ns;
    timeprecision 1ns;
    initial analog_input_channel = '0;
    // A level holds until the next set, as a settled source would
    always @(posedge sys_clk)
    begin
        if (set_en)
            analog_input_channel[set_ch] <= set_level;
    end
endmodule

`default_nettype wire
